/* verilog/sgio_pkg.sv */
// Constants for the combined segment/digital pin multiplexer.
`default_nettype none

package sgio_pkg;

  localparam int unsigned SGIO_NPINS = 32;
  localparam int unsigned SGIO_SEG_W = 6;

  localparam int unsigned SGIO_DIO_CAPABLE_PINS = 51;
  localparam int unsigned SGIO_SEG_CAPABLE_PINS = 56;
  // pins 0-3 and 26-27 of this range also carry shared functions.
  localparam logic [31:0] SGIO_SHARED_PIN_MASK  = 32'h0C00_000F;
  // segment-only pins lie outside this range and have no digital path here.
  localparam int unsigned SGIO_SEG_ONLY_PINS    = 5;

  // Memory-mapped byte addresses.
  localparam logic [15:0] SGIO_FSEL_0_7_ADDR    = 16'h240B;
  localparam logic [15:0] SGIO_FSEL_8_15_ADDR   = 16'h240A;
  localparam logic [15:0] SGIO_FSEL_16_23_ADDR  = 16'h2409;
  localparam logic [15:0] SGIO_FSEL_24_31_ADDR  = 16'h2408;
  localparam logic [15:0] SGIO_SEG_LO_BASE      = 16'h2410;
  localparam logic [15:0] SGIO_SEG_HI_BASE      = 16'h2420;
  localparam logic [15:0] SGIO_RES_SEL_BASE     = 16'h2009;
  localparam logic [15:0] SGIO_RES_SEL_LAST     = 16'h200E;
  localparam logic [15:0] SGIO_PORT_EN_ADDR     = 16'h270C;
  localparam int unsigned SGIO_PORT_EN_BIT      = 5;

  // Processor port register addresses.
  localparam logic [7:0]  SGIO_PORT_ZERO_ADDR   = 8'h80;
  localparam logic [7:0]  SGIO_PORT_ONE_ADDR    = 8'h90;
  localparam logic [7:0]  SGIO_PORT_TWO_ADDR    = 8'hA0;
  localparam logic [7:0]  SGIO_PORT_THREE_ADDR  = 8'hB0;

  // Field positions and values after reset.
  localparam int unsigned SGIO_VAL_BIT          = 0;
  localparam int unsigned SGIO_DIR_BIT          = 1;
  localparam int unsigned SGIO_PORT_DIR_LSB     = 4;
  localparam logic [7:0]  SGIO_PORT_RESET       = 8'hF0;

  // Resource selector codes and the routable pin range.
  localparam logic [2:0]  SGIO_RES_NONE         = 3'h0;
  localparam logic [2:0]  SGIO_RES_RESERVED     = 3'h1;
  localparam logic [2:0]  SGIO_RES_COUNTER_ZERO = 3'h2;
  localparam logic [2:0]  SGIO_RES_COUNTER_ONE  = 3'h3;
  localparam logic [2:0]  SGIO_RES_HIGH_INT     = 3'h4;
  localparam logic [2:0]  SGIO_RES_LOW_INT      = 3'h5;
  localparam int unsigned SGIO_ROUTE_FIRST      = 2;
  localparam int unsigned SGIO_ROUTE_LAST       = 11;

endpackage

`default_nettype wire

/* verilog/sgio_route_if.sv */
// Link between the register core and the input synchroniser/router.
`default_nettype none

interface sgio_route_if;
  logic [31:0]      pin_sync;
  logic [11:0][2:0] res_sel;

  modport router (output pin_sync, input res_sel);
  modport core (input pin_sync, output res_sel);
endinterface

`default_nettype wire

/* verilog/sgio_in_route.sv */
// Pin input synchroniser and internal resource router.
`default_nettype none

module sgio_in_route
  import sgio_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [31:0] pin_in,
  sgio_route_if.router     rif,
  output logic             counter_zero_clock,
  output logic             counter_one_clock,
  output logic             high_priority_io_interrupt,
  output logic             low_priority_io_interrupt
);

  typedef struct packed {
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic [3:0]  res;
  } sgio_route_state_t;

  sgio_route_state_t s_ff;
  sgio_route_state_t nxt_s;

  // The first stage feeds only the second; all users read the second stage.
  always_comb begin
    nxt_s       = s_ff;
    nxt_s.sync1 = pin_in;
    nxt_s.sync2 = s_ff.sync1;
    nxt_s.res   = 4'h0;
    // only pins 2 to 11 are looked at.
    for (int i = SGIO_ROUTE_FIRST; i <= SGIO_ROUTE_LAST; i++) begin
      // OR of pins, regardless of direction.
      unique case (rif.res_sel[i])
        SGIO_RES_COUNTER_ZERO: nxt_s.res[0] = nxt_s.res[0] | s_ff.sync2[i];
        SGIO_RES_COUNTER_ONE:  nxt_s.res[1] = nxt_s.res[1] | s_ff.sync2[i];
        SGIO_RES_HIGH_INT:     nxt_s.res[2] = nxt_s.res[2] | s_ff.sync2[i];
        SGIO_RES_LOW_INT:      nxt_s.res[3] = nxt_s.res[3] | s_ff.sync2[i];
        default: ;  // None, reserved and unused codes route nothing.
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // the core reads the synchronized level.
  assign rif.pin_sync               = s_ff.sync2;
  assign counter_zero_clock         = s_ff.res[0];
  assign counter_one_clock          = s_ff.res[1];
  assign high_priority_io_interrupt = s_ff.res[2];
  assign low_priority_io_interrupt  = s_ff.res[3];

endmodule

`default_nettype wire

/* verilog/sgio_pin_mux.sv */
// Register map and pin multiplexer for combined segment/digital pins 0 to 31.
`default_nettype none

module sgio_pin_mux
  import sgio_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  input  wire logic [15:0]          ioram_addr,
  input  wire logic                 ioram_wr,
  input  wire logic [7:0]           ioram_wdata,
  output logic [7:0]                ioram_rdata,
  input  wire logic [7:0]           sfr_addr,
  input  wire logic                 sfr_wr,
  input  wire logic [7:0]           sfr_wdata,
  output logic [7:0]                sfr_rdata,
  input  wire logic [31:0]          pin_in,
  output logic [31:0]               pin_out,
  output logic [31:0]               pin_oe,
  output logic [31:0]               seg_en,
  output logic [31:0][5:0]          segment_pattern,
  output logic                      counter_zero_clock,
  output logic                      counter_one_clock,
  output logic                      high_priority_io_interrupt,
  output logic                      low_priority_io_interrupt
);

  typedef struct packed {
    logic [31:0]      fsel;
    logic [15:0][5:0] seg_lo;
    logic [15:0][5:0] seg_hi;
    logic [3:0][7:0]  port;
    logic [11:0][2:0] res_sel;
    logic             port_en;
    logic [7:0]       ioram_rdata;
    logic [7:0]       sfr_rdata;
    logic [31:0]      pin_out;
    logic [31:0]      pin_oe;
    logic [31:0]      seg_en;
    logic [31:0][5:0] seg_out;
  } sgio_core_state_t;

  sgio_core_state_t s_ff;
  sgio_core_state_t nxt_s;

  sgio_route_if rif ();

  sgio_in_route u_in_route (
    .ref_clk                    (ref_clk),
    .rstn                       (rstn),
    .pin_in                     (pin_in),
    .rif                        (rif),
    .counter_zero_clock         (counter_zero_clock),
    .counter_one_clock          (counter_one_clock),
    .high_priority_io_interrupt (high_priority_io_interrupt),
    .low_priority_io_interrupt  (low_priority_io_interrupt)
  );

  // Address window tests shared by the read and the write paths.
  function automatic logic is_seg_lo(input logic [15:0] a);
    return a[15:4] == SGIO_SEG_LO_BASE[15:4];
  endfunction

  function automatic logic is_seg_hi(input logic [15:0] a);
    return a[15:4] == SGIO_SEG_HI_BASE[15:4];
  endfunction

  function automatic logic is_res_sel(input logic [15:0] a);
    return (a >= SGIO_RES_SEL_BASE) && (a <= SGIO_RES_SEL_LAST);
  endfunction

  function automatic logic [3:0] sfr_port_index(input logic [7:0] a);
    unique case (a)
      SGIO_PORT_ZERO_ADDR:  return 4'h1;
      SGIO_PORT_ONE_ADDR:   return 4'h2;
      SGIO_PORT_TWO_ADDR:   return 4'h4;
      SGIO_PORT_THREE_ADDR: return 4'h8;
      default:              return 4'h0;
    endcase
  endfunction

  logic [2:0] res_byte;
  logic [3:0] rd_port;
  logic [3:0] wr_port;
  logic [3:0] dir4;

  assign res_byte = 3'(ioram_addr - SGIO_RES_SEL_BASE);
  assign rd_port  = sfr_port_index(sfr_addr);
  assign wr_port  = sfr_port_index(sfr_addr);

  always_comb begin
    nxt_s       = s_ff;
    dir4        = 4'h0;

    // Memory-mapped writes.
    if (ioram_wr) begin
      // function-select bytes, one bit per pin.
      unique case (ioram_addr)
        SGIO_FSEL_0_7_ADDR:   nxt_s.fsel[7:0]   = ioram_wdata;
        SGIO_FSEL_8_15_ADDR:  nxt_s.fsel[15:8]  = ioram_wdata;
        SGIO_FSEL_16_23_ADDR: nxt_s.fsel[23:16] = ioram_wdata;
        SGIO_FSEL_24_31_ADDR: nxt_s.fsel[31:24] = ioram_wdata;
        SGIO_PORT_EN_ADDR:    nxt_s.port_en     = ioram_wdata[SGIO_PORT_EN_BIT];
        default: ;
      endcase
      if (is_seg_lo(ioram_addr)) begin
        nxt_s.seg_lo[ioram_addr[3:0]] = ioram_wdata[5:0];
      end
      // high pin pattern bytes, which also hold value and direction.
      if (is_seg_hi(ioram_addr)) begin
        nxt_s.seg_hi[ioram_addr[3:0]] = ioram_wdata[5:0];
      end
      // selectors exist only for pins 2 to 11; the first byte holds pins 0 and 1.
      // Both halves of that byte stay zero, so a fixed pin can never reach a resource.
      if (is_res_sel(ioram_addr) && (res_byte != 3'h0)) begin
        nxt_s.res_sel[{res_byte, 1'b0}] = ioram_wdata[2:0];
        nxt_s.res_sel[{res_byte, 1'b1}] = ioram_wdata[6:4];
      end
    end

    // processor port writes for pins 0 to 15.
    if (sfr_wr) begin
      for (int p = 0; p < 4; p++) begin
        if (wr_port[p]) begin
          nxt_s.port[p] = sfr_wdata;
        end
      end
    end

    // Memory-mapped read data, registered; unmapped addresses read zero.
    nxt_s.ioram_rdata = 8'h00;
    unique case (ioram_addr)
      SGIO_FSEL_0_7_ADDR:   nxt_s.ioram_rdata = s_ff.fsel[7:0];
      SGIO_FSEL_8_15_ADDR:  nxt_s.ioram_rdata = s_ff.fsel[15:8];
      SGIO_FSEL_16_23_ADDR: nxt_s.ioram_rdata = s_ff.fsel[23:16];
      SGIO_FSEL_24_31_ADDR: nxt_s.ioram_rdata = s_ff.fsel[31:24];
      SGIO_PORT_EN_ADDR:    nxt_s.ioram_rdata[SGIO_PORT_EN_BIT] = s_ff.port_en;
      default: ;
    endcase
    if (is_seg_lo(ioram_addr)) begin
      nxt_s.ioram_rdata = {2'b00, s_ff.seg_lo[ioram_addr[3:0]]};
    end
    if (is_seg_hi(ioram_addr)) begin
      nxt_s.ioram_rdata = {2'b00, s_ff.seg_hi[ioram_addr[3:0]]};
      // an input pin in digital use reads its pin level.
      if (!s_ff.fsel[16 + ioram_addr[3:0]] && !s_ff.seg_hi[ioram_addr[3:0]][SGIO_DIR_BIT]) begin
        nxt_s.ioram_rdata[SGIO_VAL_BIT] = rif.pin_sync[16 + ioram_addr[3:0]];
      end
    end
    if (is_res_sel(ioram_addr)) begin
      nxt_s.ioram_rdata = {1'b0, s_ff.res_sel[{res_byte, 1'b1}],
                           1'b0, s_ff.res_sel[{res_byte, 1'b0}]};
    end

    // Port read data: output bits read the latch, input bits the pin.
    nxt_s.sfr_rdata = 8'h00;
    for (int p = 0; p < 4; p++) begin
      if (rd_port[p]) begin
        nxt_s.sfr_rdata = s_ff.port[p];
        for (int b = 0; b < 4; b++) begin
          if (!s_ff.port[p][SGIO_PORT_DIR_LSB + b]) begin
            nxt_s.sfr_rdata[b] = rif.pin_sync[4 * p + b];
          end
        end
      end
    end

    // Pin drive, registered so that outputs come straight from flops.
    for (int i = 0; i < 16; i++) begin
      dir4 = s_ff.port[i / 4][7:4];
      // segment drive only in LCD use.
      nxt_s.seg_en[i]  = s_ff.fsel[i];
      nxt_s.seg_out[i] = s_ff.seg_lo[i];
      nxt_s.pin_out[i] = s_ff.port[i / 4][i % 4];
      // low pins stay disabled until the port enable is set.
      nxt_s.pin_oe[i]  = !s_ff.fsel[i] && dir4[i % 4] && s_ff.port_en;
    end
    for (int i = 0; i < 16; i++) begin
      // value and direction share the pattern byte.
      nxt_s.seg_en[16 + i]  = s_ff.fsel[16 + i];
      nxt_s.seg_out[16 + i] = s_ff.seg_hi[i];
      nxt_s.pin_out[16 + i] = s_ff.seg_hi[i][SGIO_VAL_BIT];
      // driver enabled only for digital outputs.
      nxt_s.pin_oe[16 + i]  = !s_ff.fsel[16 + i] && s_ff.seg_hi[i][SGIO_DIR_BIT];
    end
  end

  // reset gives digital use, low pins as disabled outputs, high pins as inputs.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_ff      <= '0;
      s_ff.port <= {4{SGIO_PORT_RESET}};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rif.res_sel     = s_ff.res_sel;
  assign ioram_rdata     = s_ff.ioram_rdata;
  assign sfr_rdata       = s_ff.sfr_rdata;
  assign pin_out         = s_ff.pin_out;
  assign pin_oe          = s_ff.pin_oe;
  assign seg_en          = s_ff.seg_en;
  assign segment_pattern = s_ff.seg_out;

endmodule

`default_nettype wire

/* tb/sgio_pin_mux_sva.sv */
// Concurrent checks on the ports of the combined pin multiplexer.
`default_nettype none
module sgio_pin_mux_sva
  import sgio_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rstn,
  input wire logic [15:0]       ioram_addr,
  input wire logic              ioram_wr,
  input wire logic [7:0]        ioram_wdata,
  input wire logic [7:0]        ioram_rdata,
  input wire logic [7:0]        sfr_addr,
  input wire logic              sfr_wr,
  input wire logic [7:0]        sfr_wdata,
  input wire logic [31:0]       pin_out,
  input wire logic [31:0]       pin_oe,
  input wire logic [31:0]       seg_en,
  input wire logic [31:0][5:0]  segment_pattern
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // A byte write takes effect at the pins two edges after its strobe.
  sequence s_io_wr(a);
    ioram_wr && ioram_addr == a;
  endsequence
  sequence s_io_landed(a);
    s_io_wr(a) ##2 1'b1;
  endsequence

  seg_select_a: assert property (s_io_landed(SGIO_FSEL_16_23_ADDR) |->
    seg_en[23:16] == $past(ioram_wdata, 2)) else $error("Select byte not applied.");
  pattern_low_a: assert property (s_io_landed(SGIO_SEG_LO_BASE) |->
    segment_pattern[0] == $past(ioram_wdata[5:0], 2)) else $error("Pin 0 pattern wrong.");
  pattern_high_a: assert property (s_io_landed(SGIO_SEG_HI_BASE) |->
    segment_pattern[16] == $past(ioram_wdata[5:0], 2)) else $error("Pin 16 pattern wrong.");
  pin16_drive_a: assert property (s_io_wr(SGIO_SEG_HI_BASE) ##2 !seg_en[16] |->
    pin_out[16] == $past(ioram_wdata[0], 2) && pin_oe[16] == $past(ioram_wdata[1], 2))
    else $error("Pin 16 value or direction wrong.");
  port_drive_a: assert property (sfr_wr && sfr_addr == SGIO_PORT_TWO_ADDR
    ##2 seg_en[11:8] == 4'h0 |-> pin_out[11:8] == $past(sfr_wdata[3:0], 2))
    else $error("Port two value not driven.");
  seg_no_drive_a: assert property ((seg_en & pin_oe) == 32'h0000_0000)
    else $error("Segment pin has its driver on.");
  reset_quiet_a: assert property ($rose(rstn) |-> pin_oe == 32'h0000_0000 &&
    seg_en == 32'h0000_0000) else $error("Pins not quiet after reset.");
  pattern_top_a: assert property (ioram_addr inside {[16'h2410:16'h242F]} |=>
    ioram_rdata[7:6] == 2'b00) else $error("Pattern byte top bits set.");
endmodule
`default_nettype wire

/* tb/sgio_pin_load.sv */
// External loads and switches that sit on the combined pins.
`default_nettype none
module sgio_pin_load (
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] ext_level,
  output logic      [31:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // A driven pin shows the device level, since a switch cannot overpower the driver.
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule
`default_nettype wire

/* tb/sgio_pin_mux_test.sv */
// Self-checking bench for the combined pin multiplexer.
`default_nettype none
module sgio_pin_mux_test
  import sgio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rstn = 1'b0, ioram_wr = 1'b0, sfr_wr = 1'b0;
  logic [15:0] ioram_addr = 16'h0000;
  logic [7:0] ioram_wdata = 8'h00, sfr_addr = 8'h00, sfr_wdata = 8'h00;
  logic [7:0] ioram_rdata, sfr_rdata, r, v, x, pat [32];
  logic counter_zero_clock, counter_one_clock;
  logic high_priority_io_interrupt, low_priority_io_interrupt;
  logic [3:0] res_seen;
  logic [31:0] pin_in, pin_out, pin_oe, seg_en, e_oe, e_out, ext_level = 32'h0000_0000;
  logic [31:0][5:0] segment_pattern;
  int mismatches = 0, n_tests = 0;

  sgio_pin_mux u_dut (.*);
  sgio_pin_load u_load (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
    .pin_in(pin_in));

  // Resource outputs gathered in selector code order for one compare.
  assign res_seen = {low_priority_io_interrupt, high_priority_io_interrupt,
                     counter_one_clock, counter_zero_clock};

  // The clock toggles every half period of 2 ns.
  always #2 ref_clk = ~ref_clk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Both buses see the address; only the chosen strobe rises, then pins settle.
  task automatic wr(input bit s, input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {sfr_addr, ioram_addr, sfr_wdata, ioram_wdata} = {a[7:0], a, d, d};
    {sfr_wr, ioram_wr} = {s, !s};
    @(negedge ref_clk);
    {sfr_wr, ioram_wr} = 2'b00;
    repeat (4) @(negedge ref_clk);
  endtask

  task automatic rd(input bit s, input logic [15:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    {sfr_addr, ioram_addr} = {a[7:0], a};
    @(negedge ref_clk);
    d = s ? sfr_rdata : ioram_rdata;
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // A hang is cut short well past the expected run length.
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    test_done();
  end

  // Main sequence: reset, selects, patterns, digital pins, ports, routing.
  initial begin
    r = 8'($urandom(32'hd26a));
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    for (int p = 0; p < 4; p++) begin
      rd(1'b1, 16'h0080 + 16'(p * 16), v);
      check("port reset", 32'(v), 32'h0000_00F0);
    end
    check("oe reset", pin_oe, 32'h0000_0000);
    rd(1'b0, 16'h2500, v);
    check("unmapped read", 32'(v), 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      r = 8'($urandom);
      wr(1'b0, SGIO_FSEL_24_31_ADDR + 16'(k), r);
      rd(1'b0, SGIO_FSEL_24_31_ADDR + 16'(k), v);
      check("select read", 32'(v), 32'(r));
      check("select pins", 32'(seg_en[8 * (3 - k) +: 8]), 32'(r));
      wr(1'b0, SGIO_FSEL_24_31_ADDR + 16'(k), 8'hFF);
    end
    for (int p = 0; p < 32; p++) begin
      pat[p] = 8'($urandom);
      wr(1'b0, SGIO_SEG_LO_BASE + 16'(p), pat[p]);
      rd(1'b0, SGIO_SEG_LO_BASE + 16'(p), v);
      check("pattern read", 32'(v), 32'(pat[p] & 8'h3F));
      check("pattern pins", 32'(segment_pattern[p]), 32'(pat[p][5:0]));
    end
    wr(1'b0, SGIO_PORT_EN_ADDR, 8'h20);
    check("segment oe", pin_oe, 32'h0000_0000);
    ext_level = $urandom;
    for (int k = 0; k < 4; k++)
      wr(1'b0, SGIO_FSEL_24_31_ADDR + 16'(k), 8'h00);
    for (int p = 0; p < 16; p++) begin
      e_oe[p + 16] = pat[p + 16][1];
      e_out[p + 16] = pat[p + 16][0];
    end
    check("oe after enable", pin_oe, {e_oe[31:16], 16'hFFFF});
    check("out high pins", {16'h0000, pin_out[31:16]}, {16'h0000, e_out[31:16]});
    for (int p = 16; p < 32; p++) begin
      rd(1'b0, SGIO_SEG_LO_BASE + 16'(p), v);
      x = {2'b00, pat[p][5:1], pat[p][1] ? pat[p][0] : ext_level[p]};
      check("pin byte read", 32'(v), 32'(x));
    end
    // Pin 16 is now digital, so its byte drives value and direction.
    wr(1'b0, SGIO_SEG_HI_BASE, 8'h03);
    check("pin16 drive", 32'({pin_oe[16], pin_out[16]}), 32'h0000_0003);
    for (int k = 0; k < 4; k++) begin
      r = 8'($urandom);
      wr(1'b1, 16'h0080 + 16'(k * 16), r);
      rd(1'b1, 16'h0080 + 16'(k * 16), v);
      x = {r[7:4], r[3:0] & r[7:4] | ext_level[4 * k +: 4] & ~r[7:4]};
      check("port read", 32'(v), 32'(x));
      check("port oe", 32'(pin_oe[4 * k +: 4]), 32'(r[7:4]));
      check("port out", 32'(pin_out[4 * k +: 4] & r[7:4]), 32'(r[3:0] & r[7:4]));
    end
    wr(1'b1, 16'h0080, 8'h00);
    wr(1'b0, SGIO_RES_SEL_BASE, 8'h44);
    rd(1'b0, SGIO_RES_SEL_BASE, v);
    check("fixed pin selector", 32'(v), 32'h0000_0000);
    // The last selector byte serves pins 10 and 11, both routable.
    wr(1'b0, SGIO_RES_SEL_LAST, 8'h55);
    rd(1'b0, SGIO_RES_SEL_LAST, v);
    check("last pin selector", 32'(v), 32'h0000_0055);
    wr(1'b0, SGIO_RES_SEL_LAST, 8'h00);
    // Codes 1, 6 and 7 route nothing; pins 0 and 1 sit high but stay unrouted.
    for (int c = 1; c < 8; c++) begin
      wr(1'b0, SGIO_RES_SEL_BASE + 16'h0001, {1'b0, 3'(c), 1'b0, 3'(c)});
      for (int m = 1; m < 4; m++) begin
        ext_level[3:0] = {2'(m % 3), 2'b11};
        x = (m < 3 && c > 1 && c < 6) ? 8'(1 << (c - 2)) : 8'h00;
        repeat (6) @(negedge ref_clk);
        check("routed resource", 32'(res_seen), 32'(x));
      end
    end
    test_done();
  end
endmodule

bind sgio_pin_mux sgio_pin_mux_sva u_sva (.ref_clk, .rstn, .ioram_addr, .ioram_wr,
  .ioram_wdata, .ioram_rdata, .sfr_addr, .sfr_wr, .sfr_wdata, .pin_out, .pin_oe, .seg_en,
  .segment_pattern);
`default_nettype wire
